/* File: core/ppo_defs.vh */
`ifndef PPO_DEFS_VH
`define PPO_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define PPO_CLK_PERIOD_NS 100
`define PPO_SW_PERIOD_NS 1000
`define PPO_SW_PERIOD_CYC (`PPO_SW_PERIOD_NS / `PPO_CLK_PERIOD_NS)
`define PPO_PRIMARY_MAX_CYC (`PPO_SW_PERIOD_CYC / 2)

// ****************************************
// Register indexes (byte address is index times four)
// ****************************************
`define PPO_IDX_STATUS 6'h00
`define PPO_IDX_MODE 6'h01
`define PPO_IDX_PROF 6'h07
`define PPO_IDX_PROF_CTL 6'h08
`define PPO_IDX_SET1 6'h09
`define PPO_IDX_CHG 6'h0A
`define PPO_IDX_FIX 6'h0B
`define PPO_IDX_CAPMAX 6'h0C
`define PPO_IDX_MARGIN 6'h0D

// ****************************************
// Field positions
// ****************************************
`define PPO_ST_READY 0
`define PPO_ST_STATE_LO 1
`define PPO_ST_STATE_HI 2
`define PPO_ST_ALARM 5
`define PPO_MODE_EOD 0
`define PPO_MODE_ECM 1
`define PPO_MODE_ACT 2
`define PPO_PROF_RST 3
`define PPO_CHG_HIZ 4
`define PPO_CAPMAX_BIT 4

// ****************************************
// Reset values and levels
// ****************************************
`define PPO_VSET_RST 4'h8
`define PPO_PROF_RST_VAL 6'h01
`define PPO_MARGIN_RST 2'h3
`define PPO_CHG_RST 8'h00
`define PPO_FIX_RST 4'h0
`define PPO_CAPMAX_RST 1'b0
`define PPO_LEVEL_HI 4'hF
`define PPO_LEVEL_LO 4'hB
`define PPO_LEVEL_MIN 4'h0
`define PPO_NUM_PROF 63

// ****************************************
// Operating states
// ****************************************
`define PPO_S_STANDBY 2'h0
`define PPO_S_CHARGE 2'h1
`define PPO_S_ACTIVE 2'h2

`endif

/* File: core/ppo_power_ctrl.v */
// What this block does
// - Active undervoltage sets alarm status bit five.
// - Alarm set drives ready pin low.
// - Alarm and low ready held until Charge.
// - Converter switches at fixed 1 MHz, peak-current.
// - Charge below 1.6 V uses precharge switch.
// - Charge above 1.6 V runs boost converter.
// - Boost: cap side plus third, then second plus output.
// - Buck: high plus output, then high plus third.
// - Permanent output on battery, on output when Active.
// - Hi-Z bit resets zero; output follows battery.
// - Hi-Z bit set floats output outside Active.
// - Active regulates to four-bit voltage field.
// - Voltage field resets to the 3.0 V code.
// - Voltage rewrite in Active keeps Active.
// - Sixty-three learned levels, one location each.
// - Profile zero uses the fixed charge level.
// - Residual capacitor level steers next charge level.
// - Reset selects profile one, safest margin.
// - Two-bit margin picks one of four thresholds.
// - Ready output and bit low in Standby.
// - On-demand moves Charge to Active at end level.
// - Above margin after Active lowers level one step.
`timescale 1ns/100ps
`include "ppo_defs.vh"

module ppo_power_ctrl (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Analog comparator results, asynchronous
  input wire output_under_target,
  input wire cap_above_precharge,
  input wire cap_at_end_level,
  input wire cap_above_margin,
  input wire peak_current_trip,
  // Ready pin
  output reg ready_out,
  // Output path switches
  output reg permanent_to_battery,
  output reg permanent_to_output,
  output reg output_to_battery,
  output reg output_from_converter,
  // Converter switches
  output reg precharge_switch,
  output reg cap_side_switch,
  output reg buck_high_switch,
  output reg boost_second_switch,
  output reg boost_third_switch,
  output reg output_side_switch,
  // Analog settings
  output reg [3:0] vset_level,
  output reg [3:0] end_charge_level,
  output reg [1:0] margin_level,
  output reg [2:0] charge_current_setting
);

  // ****************************************
  // Comparator synchronisers
  // ****************************************
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  wire under_s;
  wire precharge_done_s;
  wire at_end_s;
  wire above_margin_s;
  wire peak_s;

  // Comparator edges are free running; one flop alone could go metastable
  // Two stages; only the second stage is read by logic
  always @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= 5'h0_0;
      sync2_q <= 5'h0_0;
    end else begin
      sync1_q <= {peak_current_trip, cap_above_margin, cap_at_end_level, cap_above_precharge, output_under_target};
      sync2_q <= sync1_q;
    end
  end
  assign under_s = sync2_q[0];
  assign precharge_done_s = sync2_q[1];
  assign at_end_s = sync2_q[2];
  assign above_margin_s = sync2_q[3];
  assign peak_s = sync2_q[4];
  // A comparator edge shows at the switch outputs three clocks later; a peak trip takes four, through primary_q

  // ****************************************
  // Registers
  // ****************************************
  reg mode_eod_q;
  reg mode_ecm_q;
  reg mode_act_q;
  reg [5:0] prof_q;
  reg [3:0] vset_q;
  reg [7:0] chg_q;
  reg [3:0] fix_q;
  reg capmax_q;
  reg [1:0] margin_q;
  reg alarm_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  // One word per profile; profile zero is the fixed path and has no entry
  reg [3:0] level_mem [1:`PPO_NUM_PROF];
  integer i;

  wire [5:0] idx;
  wire setup_ph;
  wire wr_go;
  wire hiz;
  wire opt_on;
  wire [3:0] cap_max_level;
  wire [3:0] cur_level;
  reg mapped;
  reg [31:0] rd_mux;

  // Word index; the two low address bits are ignored
  assign idx = paddr[7:2];
  assign setup_ph = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite;
  assign hiz = chg_q[`PPO_CHG_HIZ];
  assign opt_on = (prof_q != 6'h0_0);
  assign cap_max_level = capmax_q ? `PPO_LEVEL_HI : `PPO_LEVEL_LO;
  assign cur_level = opt_on ? level_mem[prof_q] : fix_q;

  // Read decode; unmapped indexes give slave error
  // Status is read live, so a read never disturbs the alarm
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      `PPO_IDX_STATUS: begin
        rd_mux[`PPO_ST_READY] = ready_out;
        rd_mux[`PPO_ST_STATE_HI:`PPO_ST_STATE_LO] = state_q;
        rd_mux[`PPO_ST_ALARM] = alarm_q;
      end
      `PPO_IDX_MODE: rd_mux[2:0] = {mode_act_q, mode_ecm_q, mode_eod_q};
      `PPO_IDX_PROF: rd_mux[5:0] = prof_q;
      `PPO_IDX_PROF_CTL: rd_mux[3:0] = cur_level;
      `PPO_IDX_SET1: rd_mux[3:0] = vset_q;
      `PPO_IDX_CHG: rd_mux[7:0] = chg_q;
      `PPO_IDX_FIX: rd_mux[3:0] = fix_q;
      `PPO_IDX_CAPMAX: rd_mux[`PPO_CAPMAX_BIT] = capmax_q;
      `PPO_IDX_MARGIN: rd_mux[1:0] = margin_q;
      default: mapped = 1'b0;
    endcase
  end

  // Zero-wait APB: answer raised in the setup cycle, seen in the access cycle
  // Writes land only on the access edge, so a slow master never writes twice
  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Software-written configuration
  // Reserved bits are dropped on write and read back as zero
  always @(posedge ref_clk) begin
    if (rst) begin
      mode_eod_q <= 1'b0;
      mode_ecm_q <= 1'b0;
      mode_act_q <= 1'b0;
      prof_q <= `PPO_PROF_RST_VAL;
      vset_q <= `PPO_VSET_RST;
      chg_q <= `PPO_CHG_RST;
      fix_q <= `PPO_FIX_RST;
      capmax_q <= `PPO_CAPMAX_RST;
      margin_q <= `PPO_MARGIN_RST;
    end else if (wr_go) begin
      case (idx)
        `PPO_IDX_MODE: begin
          mode_eod_q <= pwdata[`PPO_MODE_EOD];
          mode_ecm_q <= pwdata[`PPO_MODE_ECM];
          mode_act_q <= pwdata[`PPO_MODE_ACT];
        end
        `PPO_IDX_PROF: prof_q <= pwdata[5:0];
        `PPO_IDX_SET1: vset_q <= pwdata[3:0];
        `PPO_IDX_CHG: chg_q <= pwdata[7:0];
        `PPO_IDX_FIX: fix_q <= pwdata[3:0];
        `PPO_IDX_CAPMAX: capmax_q <= pwdata[`PPO_CAPMAX_BIT];
        `PPO_IDX_MARGIN: margin_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Operating state machine
  // ****************************************
  // Mode bits steer the state; the comparator only ends an on-demand charge
  always @* begin
    state_d = state_q;
    case (state_q)
      `PPO_S_STANDBY: begin
        if (mode_eod_q | mode_ecm_q) begin
          state_d = `PPO_S_CHARGE;
        end
      end
      `PPO_S_CHARGE: begin
        if (~mode_eod_q & ~mode_ecm_q) begin
          state_d = `PPO_S_STANDBY;
        end else if (mode_act_q) begin
          state_d = `PPO_S_ACTIVE;
        end else if (mode_eod_q & ~mode_ecm_q & at_end_s) begin
          state_d = `PPO_S_ACTIVE;
        end
      end
      `PPO_S_ACTIVE: begin
        // Voltage writes never leave Active; only mode bits do
        if (mode_ecm_q) begin
          if (~mode_act_q) begin
            state_d = `PPO_S_CHARGE;
          end
        end else if (~mode_eod_q) begin
          state_d = `PPO_S_STANDBY;
        end
      end
      default: state_d = `PPO_S_STANDBY;
    endcase
  end

  // State register; reset always lands in Standby
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= `PPO_S_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Learned charge levels
  // ****************************************
  // Stepping happens once per Active cycle, on its exit edge
  // Reset fills every profile with the top level, so the first charge is the safe one
  // A profile reset request beats the stepping of the same cycle
  // Level zero and the ceiling stop the step, so the count never wraps
  wire active_exit;
  assign active_exit = (state_q == `PPO_S_ACTIVE) & (state_d != `PPO_S_ACTIVE);

  always @(posedge ref_clk) begin
    if (rst) begin
      for (i = 1; i <= `PPO_NUM_PROF; i = i + 1) begin
        level_mem[i] <= `PPO_LEVEL_HI;
      end
    end else if (wr_go & (idx == `PPO_IDX_PROF_CTL) & pwdata[`PPO_PROF_RST] & opt_on) begin
      level_mem[prof_q] <= cap_max_level;
    end else if (active_exit & opt_on) begin
      if (above_margin_s) begin
        if (level_mem[prof_q] != `PPO_LEVEL_MIN) begin
          level_mem[prof_q] <= level_mem[prof_q] - 4'h1;
        end
      end else if (level_mem[prof_q] < cap_max_level) begin
        level_mem[prof_q] <= level_mem[prof_q] + 4'h1;
      end
    end
  end

  // ****************************************
  // Output alarm
  // ****************************************
  // Set wins over clear: a sag seen on the edge that leaves Active for Charge
  // keeps the flag, so a late undervoltage is never lost
  always @(posedge ref_clk) begin
    if (rst) begin
      alarm_q <= 1'b0;
    end else if ((state_q == `PPO_S_ACTIVE) & under_s) begin
      alarm_q <= 1'b1;
    end else if ((state_q != `PPO_S_CHARGE) & (state_d == `PPO_S_CHARGE)) begin
      alarm_q <= 1'b0;
    end
  end

  // ****************************************
  // Switching cadence
  // ****************************************
  reg [3:0] cyc_q;
  reg primary_q;
  // Period end and primary limit cut to the counter width on purpose
  localparam [31:0] sw_last_w = `PPO_SW_PERIOD_CYC - 1;
  localparam [31:0] pri_last_w = `PPO_PRIMARY_MAX_CYC - 1;
  localparam [3:0] sw_last = sw_last_w[3:0];
  localparam [3:0] pri_last = pri_last_w[3:0];

  // Peak trip may end the primary early; each period start restarts it
  // Primary phase opens each period, ends on peak current or half period
  always @(posedge ref_clk) begin
    if (rst) begin
      cyc_q <= 4'h0;
      primary_q <= 1'b0;
    end else if (cyc_q == sw_last) begin
      cyc_q <= 4'h0;
      primary_q <= 1'b1;
    end else begin
      cyc_q <= cyc_q + 4'h1;
      if (peak_s | (cyc_q >= pri_last)) begin
        primary_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Switch decode and output registers
  // ****************************************
  wire in_act;
  wire in_chg;
  wire boost_on;
  wire buck_on;
  assign in_act = (state_q == `PPO_S_ACTIVE);
  assign in_chg = (state_q == `PPO_S_CHARGE);
  assign boost_on = in_chg & precharge_done_s & ~at_end_s;
  assign buck_on = in_act;

  // Boost and buck never share a state, so the switch pairs cannot fight
  // Decoded from state, hi-Z bit, comparators and switching phase, then registered to keep outputs glitch free
  always @(posedge ref_clk) begin
    if (rst) begin
      permanent_to_battery <= 1'b1;
      permanent_to_output <= 1'b0;
      output_to_battery <= 1'b1;
      output_from_converter <= 1'b0;
      precharge_switch <= 1'b0;
      cap_side_switch <= 1'b0;
      buck_high_switch <= 1'b0;
      boost_second_switch <= 1'b0;
      boost_third_switch <= 1'b0;
      output_side_switch <= 1'b0;
      ready_out <= 1'b0;
      vset_level <= `PPO_VSET_RST;
      end_charge_level <= `PPO_LEVEL_HI;
      margin_level <= `PPO_MARGIN_RST;
      charge_current_setting <= 3'h0;
    end else begin
      permanent_to_battery <= ~in_act;
      permanent_to_output <= in_act;
      output_to_battery <= ~in_act & ~hiz;
      output_from_converter <= in_act;
      precharge_switch <= in_chg & ~precharge_done_s;
      cap_side_switch <= boost_on & primary_q;
      boost_third_switch <= (boost_on & primary_q) | (buck_on & ~primary_q);
      boost_second_switch <= boost_on & ~primary_q;
      output_side_switch <= (boost_on & ~primary_q) | (buck_on & primary_q);
      buck_high_switch <= buck_on;
      ready_out <= ~alarm_q & (state_q != `PPO_S_STANDBY);
      vset_level <= vset_q;
      // Fixed level never exceeds the capacitor ceiling
      end_charge_level <= (cur_level > cap_max_level) ? cap_max_level : cur_level;
      margin_level <= margin_q;
      charge_current_setting <= chg_q[7:5];
    end
  end

endmodule // ppo_power_ctrl

/* File: bench/ppo_power_ctrl_properties.sv */
`timescale 1ns/100ps
// ****************************************
// Port checker for the power controller
// ****************************************
module ppo_props (
  // Clock, reset and bus
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  // Path switches
  input wire permanent_to_battery,
  input wire permanent_to_output,
  input wire output_to_battery,
  input wire output_from_converter,
  // Converter switches
  input wire precharge_switch,
  input wire cap_side_switch,
  input wire buck_high_switch,
  input wire boost_second_switch,
  input wire boost_third_switch,
  input wire output_side_switch,
  // Settings
  input wire [3:0] vset_level,
  input wire [1:0] margin_level
);
  // One domain, so one clock for all and one reset for all but the reset-value check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("setup not answered in one cycle");
  a_perm_excl: assert property (permanent_to_battery ^ permanent_to_output)
    else $error("permanent output on both or neither source");
  a_conv_active: assert property (output_from_converter == permanent_to_output)
    else $error("converter drive out of step with active path");
  a_out_path: assert property (!(output_to_battery && output_from_converter))
    else $error("output tied to battery and converter");
  a_boost_pri: assert property (cap_side_switch |-> boost_third_switch && !boost_second_switch && !output_side_switch)
    else $error("boost primary pair wrong");
  a_boost_sec: assert property (boost_second_switch |-> output_side_switch && !boost_third_switch && !buck_high_switch)
    else $error("boost secondary pair wrong");
  a_buck_pair: assert property (buck_high_switch |-> (output_side_switch ^ boost_third_switch) && !cap_side_switch)
    else $error("buck phase pair wrong");
  a_pre_alone: assert property (precharge_switch |-> !cap_side_switch && !boost_second_switch && !buck_high_switch)
    else $error("precharge overlaps converter");
  a_prim_bound: assert property ($rose(cap_side_switch) |-> ##[1:5] !cap_side_switch)
    else $error("primary phase over half period");
  a_reset_vals: assert property (disable iff (1'b0) rst |=> vset_level == 4'h8 && margin_level == 2'h3)
    else $error("settings not at defaults after reset");
endmodule // ppo_props

bind ppo_power_ctrl ppo_props ppo_props_inst (.ref_clk, .rst, .psel, .penable, .pready,
  .permanent_to_battery, .permanent_to_output, .output_to_battery, .output_from_converter,
  .precharge_switch, .cap_side_switch, .buck_high_switch, .boost_second_switch,
  .boost_third_switch, .output_side_switch, .vset_level, .margin_level);

/* File: bench/ppo_host_model.sv */
`timescale 1ns/100ps
// ****************************************
// Host master on the register bus
// ****************************************
module ppo_host_model (
  // Clock
  input wire ref_clk,
  // Requests
  output reg psel = 1'b0,
  output reg penable = 1'b0,
  output reg pwrite = 1'b0,
  output reg [7:0] paddr = 8'h0,
  output reg [31:0] pwdata = 32'h0,
  // Answer
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // Setup, then access held until pready; unknown result if it never comes
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    rd = 32'hxxxx_xxxx;
    err = 1'bx;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready === 1'b1) begin
      rd = prdata;
      err = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ppo_host_model

/* File: bench/tb_ppo_power_ctrl.sv */
`timescale 1ns/100ps
// ****************************************
// Bench top
// ****************************************
module tb_ppo_power_ctrl;
  typedef struct packed {
    logic wr;
    logic [5:0] idx;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } ppo_row_t;
  // Optional write, then read back with expected data and error
  localparam ppo_row_t rows [0:9] = '{
    '{1'b0, 6'h07, 32'h0, 32'h1, 1'b0}, '{1'b0, 6'h0D, 32'h0, 32'h3, 1'b0},
    '{1'b0, 6'h09, 32'h0, 32'h8, 1'b0}, '{1'b0, 6'h0A, 32'h0, 32'h0, 1'b0},
    '{1'b0, 6'h00, 32'h0, 32'h0, 1'b0}, '{1'b1, 6'h0D, 32'h0, 32'h0, 1'b0},
    '{1'b1, 6'h07, 32'h3F, 32'h3F, 1'b0}, '{1'b1, 6'h07, 32'h0, 32'h0, 1'b0},
    '{1'b0, 6'h08, 32'h0, 32'h0, 1'b0}, '{1'b1, 6'h3F, 32'hFF, 32'h0, 1'b1}};
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg output_under_target = 1'b0, cap_above_precharge = 1'b0, cap_at_end_level = 1'b0;
  reg cap_above_margin = 1'b0, peak_current_trip = 1'b0;
  wire psel, penable, pwrite, pready, pslverr;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire ready_out, permanent_to_battery, permanent_to_output, output_to_battery, output_from_converter;
  wire precharge_switch, cap_side_switch, buck_high_switch, boost_second_switch, boost_third_switch;
  wire output_side_switch;
  wire [3:0] vset_level, end_charge_level;
  wire [1:0] margin_level;
  wire [2:0] charge_current_setting;
  wire [3:0] mon = {buck_high_switch, cap_side_switch, precharge_switch, permanent_to_output};
  logic [31:0] rd;
  logic er;
  int err_count = 0, total_checks = 0, i;

  ppo_power_ctrl ppo_power_ctrl_inst (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .output_under_target, .cap_above_precharge, .cap_at_end_level,
    .cap_above_margin, .peak_current_trip, .ready_out, .permanent_to_battery, .permanent_to_output,
    .output_to_battery, .output_from_converter, .precharge_switch, .cap_side_switch, .buck_high_switch,
    .boost_second_switch, .boost_third_switch, .output_side_switch, .vset_level, .end_charge_level,
    .margin_level, .charge_current_setting);
  ppo_host_model ppo_host_model_inst (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  // Free-running 10 MHz clock
  initial forever #50 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic get(input logic [5:0] idx);
    ppo_host_model_inst.xfer(1'b0, idx, 32'h0, rd, er);
  endtask
  task automatic put(input logic [5:0] idx, input logic [31:0] d);
    ppo_host_model_inst.xfer(1'b1, idx, d, rd, er);
    check({31'h0, er === 1'bx}, 32'h0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Count buck primary cycles over one full switching period
  task automatic pri_count(input logic [31:0] exp);
    logic [31:0] c;
    c = 32'h0;
    repeat (10) begin
      @(posedge ref_clk);
      c = c + output_side_switch;
    end
    check(c, exp);
  endtask
  // One Standby to Active and back trip with the given mode word
  task automatic cycle(input logic [31:0] m);
    put(6'h01, m);
    await(0);
    put(6'h01, 32'h0);
    settle(3);
  endtask
  // Bounded wait for one monitored switch to close
  task automatic await(input int b);
    int n;
    n = 0;
    while (mon[b] !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, mon[b]}, 32'h1);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    settle(20000);
    err_count++;
    print_verdict;
  end

  // Main sequence: register rows, then state walk
  initial begin
    settle(20);
    rst <= 1'b0;
    for (i = 0; i < 10; i++) begin
      if (rows[i].wr) put(rows[i].idx, rows[i].wd);
      get(rows[i].idx);
      check(rd, rows[i].exp);
      check({31'h0, er}, {31'h0, rows[i].err});
    end
    check({30'h0, permanent_to_battery, output_to_battery}, 32'h3);
    put(6'h0A, 32'h10);
    settle(3);
    check({30'h0, output_to_battery, output_from_converter}, 32'h0);
    put(6'h01, 32'h1);
    await(1);
    cap_above_precharge <= 1'b1;
    await(2);
    cap_at_end_level <= 1'b1;
    await(0);
    await(3);
    put(6'h09, 32'hF);
    settle(2);
    check({27'h0, vset_level, permanent_to_output}, 32'h1F);
    check({30'h0, ready_out, output_from_converter}, 32'h3);
    output_under_target <= 1'b1;
    settle(5);
    output_under_target <= 1'b0;
    settle(5);
    get(6'h00);
    check(rd & 32'h27, 32'h24);
    check({31'h0, ready_out}, 32'h0);
    pri_count(32'h5);
    peak_current_trip <= 1'b1;
    settle(12);
    pri_count(32'h1);
    peak_current_trip <= 1'b0;
    put(6'h01, 32'h2);
    settle(3);
    get(6'h00);
    check(rd & 32'h27, 32'h3);
    put(6'h01, 32'h0);
    settle(3);
    get(6'h00);
    check({rd[2:0], ready_out}, 4'h0);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    get(6'h09);
    check(rd, 32'h8);
    check({30'h0, permanent_to_battery, output_to_battery}, 32'h3);
    check({28'h0, end_charge_level}, 32'hB);
    check({30'h0, margin_level}, 32'h3);
    get(6'h08);
    check(rd, 32'hF);
    put(6'h0A, 32'h60);
    put(6'h0D, 32'h1);
    put(6'h0C, 32'h10);
    put(6'h08, 32'h8);
    settle(2);
    check({25'h0, charge_current_setting, end_charge_level}, 32'h3F);
    check({30'h0, margin_level}, 32'h1);
    cap_above_margin <= 1'b1;
    cycle(32'h1);
    get(6'h08);
    check(rd, 32'hE);
    cap_above_margin <= 1'b0;
    cycle(32'h6);
    get(6'h08);
    check(rd, 32'hF);
    print_verdict;
  end
endmodule // tb_ppo_power_ctrl
